// ---- rtl/mode_ctrl_pkg.sv ----
package mode_ctrl_pkg;
    // operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_RX_ONLY,
        MODE_STANDBY,
        MODE_GO_SLEEP,
        MODE_SLEEP
    } mode_t;

    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 25;
    // filter and hold times in microseconds
    localparam int unsigned UV_FILTER_US     = 10;
    localparam int unsigned SLEEP_HOLD_US    = 50;
    localparam int unsigned UV_FILTER_CYC    = (UV_FILTER_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_HOLD_CYC   = (SLEEP_HOLD_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W            = 16;
    // edge count that closes the wake-source window
    localparam logic [2:0]  TXD_EDGE_LIMIT   = 3'h4;
    localparam logic [2:0]  TXD_EDGE_ZERO    = 3'h0;
    localparam logic [2:0]  TXD_EDGE_ONE     = 3'h1;
endpackage

// ---- rtl/hold_timer.sv ----
`timescale 1ns/1ps
// counts while cond_i holds, restarts when it drops, flags once limit passed
module hold_timer
    import mode_ctrl_pkg::*;
#(
    parameter logic [CNT_W-1:0] LIMIT = 16'h0001
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic cond_i,
    output logic      expired_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             exp_reg;
    logic             exp_next;

    // next count, restart on drop
    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (!cond_i) begin
            cnt_next = '0;
        end else if (cnt_reg >= LIMIT) begin
            exp_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired_o = exp_reg;
endmodule

// ---- rtl/can_transceiver_mode_control.sv ----
`timescale 1ns/1ps
module can_transceiver_mode_control
    import mode_ctrl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic standby_not_input_i,
    input  wire logic enable_i,
    input  wire logic txd_i,
    input  wire logic bus_rx_i,
    input  wire logic local_wake_input_i,
    input  wire logic bus_wake_i,
    input  wire logic vcc_uv_i,
    input  wire logic vio_uv_i,
    input  wire logic vbat_uv_i,
    input  wire logic vbat_powerup_i,
    input  wire logic bus_failure_i,
    input  wire logic local_failure_i,
    input  wire logic driver_off_i,
    output logic      supply_inhibit_output_o,
    output logic      split_enable_o,
    output logic      error_flag_output_o,
    output logic      rxd_o,
    output logic      mode_normal_o,
    output logic      logic_uv_flag_o,
    output logic      vbat_uv_flag_o
);
    // two-flop synchronisers for all pin inputs
    localparam int unsigned NSYNC = 13;
    logic [NSYNC-1:0] meta_reg;
    logic [NSYNC-1:0] sync_reg;
    logic             standby_not_input, en, txd, bus_rx, wk_local, wk_bus, uv_logic;
    logic             uv_bat, pwrup, bus_fail, loc_fail, drv_off, vio_uv;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {standby_not_input_i, enable_i, txd_i, bus_rx_i,
                         local_wake_input_i, bus_wake_i, vcc_uv_i, vio_uv_i,
                         vbat_uv_i, vbat_powerup_i, bus_failure_i,
                         local_failure_i, driver_off_i};
            sync_reg <= meta_reg;
        end
    end

    assign {standby_not_input, en, txd, bus_rx, wk_local, wk_bus, uv_logic, vio_uv,
            uv_bat, pwrup, bus_fail, loc_fail, drv_off} = sync_reg;

    // filter and hold timers
    logic uv_expired;
    logic gts_expired;
    logic gts_sel;
    assign gts_sel = !standby_not_input && en;

    hold_timer #(
        .LIMIT (CNT_W'(UV_FILTER_CYC))
    ) uv_filter (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .cond_i    (uv_logic || vio_uv),
        .expired_o (uv_expired)
    );

    hold_timer #(
        .LIMIT (CNT_W'(SLEEP_HOLD_CYC))
    ) sleep_hold (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .cond_i    (gts_sel),
        .expired_o (gts_expired)
    );

    // mode and flag state
    mode_t      mode_reg,      mode_next;
    logic       luv_reg,       luv_next;
    logic       buv_reg,       buv_next;
    logic       wake_reg,      wake_next;
    logic       wsrc_reg,      wsrc_next;
    logic       pwr_reg,       pwr_next;
    logic       lfail_reg,     lfail_next;
    logic       from_norm_reg, from_norm_next;
    logic [2:0] edge_reg,      edge_next;
    logic       txd_d_reg,     txd_d_next;
    logic       inh_reg,       inh_next;
    logic       split_reg,     split_next;
    logic       err_reg,       err_next;
    logic       rxd_reg,       rxd_next;
    logic       mnorm_reg,     mnorm_next;
    logic       supplies_ok;
    logic       tx_fall;

    assign supplies_ok = !uv_logic && !vio_uv;
    assign tx_fall     = txd_d_reg && !txd;

    always_comb begin
        mode_next      = mode_reg;
        luv_next       = luv_reg;
        buv_next       = buv_reg;
        wake_next      = wake_reg;
        wsrc_next      = wsrc_reg;
        pwr_next       = pwr_reg;
        lfail_next     = lfail_reg;
        from_norm_next = from_norm_reg;
        edge_next      = edge_reg;
        txd_d_next     = txd;

        // requested mode from control inputs
        case ({standby_not_input, en})
            2'b11: mode_next = MODE_NORMAL;
            2'b10: mode_next = MODE_RX_ONLY;
            2'b01: mode_next = (mode_reg == MODE_SLEEP) ? MODE_SLEEP : MODE_GO_SLEEP;
            default: mode_next = (mode_reg == MODE_SLEEP) ? MODE_SLEEP : MODE_STANDBY;
        endcase
        // mode pins leave sleep only with supplies active
        if (mode_reg == MODE_SLEEP && !supplies_ok) begin
            mode_next = MODE_SLEEP;
        end
        if (mode_reg == MODE_GO_SLEEP && gts_sel && gts_expired) begin
            mode_next = MODE_SLEEP;
        end
        // wake from sleep goes to standby
        if (mode_reg == MODE_SLEEP && (wk_local || wk_bus) && !standby_not_input) begin
            mode_next = MODE_STANDBY;
        end
        if (uv_bat) begin
            mode_next = MODE_STANDBY;
            buv_next  = 1'b1;
        end else begin
            buv_next = 1'b0;
        end
        if (uv_expired) begin
            mode_next = MODE_SLEEP;
            luv_next  = 1'b1;
        end

        // wake flag: set in low power, held until normal or receive-only
        if (mode_reg != MODE_NORMAL && mode_reg != MODE_RX_ONLY && (wk_local || wk_bus)) begin
            wake_next = 1'b1;
            if (wk_local) begin
                wsrc_next = 1'b1;
            end
        end
        // power-up flag on battery connect
        if (pwrup) begin
            pwr_next = 1'b1;
        end
        // clear on new power-up or wake, set wins
        if (!uv_expired && ((wake_next && !wake_reg) || (pwr_next && !pwr_reg))) begin
            luv_next = 1'b0;
        end

        // local failures latched in normal mode
        if (mode_reg == MODE_NORMAL && loc_fail) begin
            lfail_next = 1'b1;
        end
        // tx edge counter in normal mode
        if (mode_reg == MODE_NORMAL) begin
            if (tx_fall && edge_reg != TXD_EDGE_LIMIT) begin
                edge_next = edge_reg + TXD_EDGE_ONE;
            end
        end else begin
            edge_next = TXD_EDGE_ZERO;
        end

        // entering normal clears wake, power-up, and local failure when coming from receive-only
        if (mode_next == MODE_NORMAL && mode_reg != MODE_NORMAL) begin
            wake_next = 1'b0;
            pwr_next  = 1'b0;
            if (mode_reg == MODE_RX_ONLY) begin
                lfail_next = 1'b0;
            end
        end
        // source cleared after four edges or on leaving normal
        if (mode_reg == MODE_NORMAL
            && (edge_reg == TXD_EDGE_LIMIT || mode_next != MODE_NORMAL)) begin
            wsrc_next = 1'b0;
        end
        // wake flag cleared on entering receive-only
        if (mode_next == MODE_RX_ONLY && mode_reg != MODE_RX_ONLY) begin
            wake_next      = 1'b0;
            from_norm_next = (mode_reg == MODE_NORMAL);
        end
    end

    // output decode
    always_comb begin
        inh_next   = 1'b1;
        split_next = 1'b0;
        err_next   = 1'b1;
        rxd_next   = 1'b1;
        mnorm_next = (mode_next == MODE_NORMAL);
        case (mode_next)
            MODE_NORMAL: begin
                split_next = 1'b1;
                rxd_next   = bus_rx;
                if (edge_next != TXD_EDGE_LIMIT) begin
                    err_next = !(wsrc_next && !pwr_next);
                end else begin
                    // bus failure after edges, driver off keeps high
                    err_next = !(bus_fail && !drv_off);
                end
            end
            MODE_RX_ONLY: begin
                split_next = 1'b1;
                rxd_next   = bus_rx;
                if (from_norm_next) begin
                    err_next = !lfail_next;
                end else begin
                    err_next = !(pwr_next && supplies_ok);
                end
            end
            MODE_SLEEP: begin
                inh_next = 1'b0;
                err_next = !(wake_next && supplies_ok);
                rxd_next = !(wake_next && supplies_ok);
            end
            default: begin
                // standby and go-to-sleep wake, uv flags not shown
                inh_next = !(mode_next == MODE_GO_SLEEP && gts_expired);
                err_next = !(wake_next && supplies_ok);
                rxd_next = !(wake_next && supplies_ok);
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_reg      <= MODE_STANDBY;
            luv_reg       <= 1'b0;
            buv_reg       <= 1'b0;
            wake_reg      <= 1'b0;
            wsrc_reg      <= 1'b0;
            pwr_reg       <= 1'b0;
            lfail_reg     <= 1'b0;
            from_norm_reg <= 1'b0;
            edge_reg      <= TXD_EDGE_ZERO;
            txd_d_reg     <= 1'b1;
            inh_reg       <= 1'b1;
            split_reg     <= 1'b0;
            err_reg       <= 1'b1;
            rxd_reg       <= 1'b1;
            mnorm_reg     <= 1'b0;
        end else begin
            mode_reg      <= mode_next;
            luv_reg       <= luv_next;
            buv_reg       <= buv_next;
            wake_reg      <= wake_next;
            wsrc_reg      <= wsrc_next;
            pwr_reg       <= pwr_next;
            lfail_reg     <= lfail_next;
            from_norm_reg <= from_norm_next;
            edge_reg      <= edge_next;
            txd_d_reg     <= txd_d_next;
            inh_reg       <= inh_next;
            split_reg     <= split_next;
            err_reg       <= err_next;
            rxd_reg       <= rxd_next;
            mnorm_reg     <= mnorm_next;
        end
    end

    assign supply_inhibit_output_o = inh_reg;
    assign split_enable_o          = split_reg;
    assign error_flag_output_o     = err_reg;
    assign rxd_o                   = rxd_reg;
    assign mode_normal_o           = mnorm_reg;
    assign logic_uv_flag_o         = luv_reg;
    assign vbat_uv_flag_o          = buv_reg;
endmodule

// ---- tb/can_transceiver_mode_control_assertions.sv ----
`timescale 1ns/1ps
module can_transceiver_mode_control_assertions
    import mode_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic standby_not_input_i,
    input wire logic enable_i,
    input wire logic txd_i,
    input wire logic bus_rx_i,
    input wire logic vcc_uv_i,
    input wire logic vio_uv_i,
    input wire logic vbat_uv_i,
    input wire logic driver_off_i,
    input wire logic bus_failure_i,
    input wire logic supply_inhibit_output_o,
    input wire logic split_enable_o,
    input wire logic error_flag_output_o,
    input wire logic rxd_o,
    input wire logic mode_normal_o,
    input wire logic logic_uv_flag_o,
    input wire logic vbat_uv_flag_o
);
    logic [15:0] gs_reg, gs_next, uv_reg, uv_next;
    logic [2:0]  ec_reg, ec_next;
    logic        tq_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // sleep-select, undervoltage and tx edge counters
    always_comb begin
        gs_next = (!standby_not_input_i && enable_i) ? gs_reg + 16'h0001 : 16'h0000;
        uv_next = (vcc_uv_i || vio_uv_i) ? uv_reg + 16'h0001 : 16'h0000;
        ec_next = ec_reg;
        if (!mode_normal_o)
            ec_next = 3'h0;
        else if (tq_reg && !txd_i && ec_reg != 3'h7)
            ec_next = ec_reg + 3'h1;
    end
    always_ff @(posedge clk_i) begin
        gs_reg <= rst_b_i ? gs_next : 16'h0000;
        uv_reg <= rst_b_i ? uv_next : 16'h0000;
        ec_reg <= rst_b_i ? ec_next : 3'h0;
        tq_reg <= txd_i;
    end
    sequence s_wake_low;
        !rxd_o && !split_enable_o;
    endsequence
    property p_uv_sleep;
        uv_reg == UV_FILTER_CYC + 8 |-> !supply_inhibit_output_o && logic_uv_flag_o;
    endproperty
    a_uv_sleep: assert property (p_uv_sleep) else $error("uv did not force sleep");
    property p_vbat_standby;
        vbat_uv_i [*4] |=> vbat_uv_flag_o && !mode_normal_o && !split_enable_o;
    endproperty
    a_vbat_standby: assert property (p_vbat_standby) else $error("vbat uv no standby");
    property p_vbat_clear;
        $fell(vbat_uv_flag_o) |-> !$past(vbat_uv_i, 3);
    endproperty
    a_vbat_clear: assert property (p_vbat_clear) else $error("vbat flag cleared early");
    property p_normal_out;
        mode_normal_o |-> supply_inhibit_output_o && split_enable_o;
    endproperty
    a_normal_out: assert property (p_normal_out) else $error("normal outputs wrong");
    property p_rx_follow;
        split_enable_o && $past(split_enable_o, 3) |-> rxd_o == $past(bus_rx_i, 3);
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("rxd not following bus");
    property p_src_window;
        (mode_normal_o && ec_reg >= 3'h4 && !bus_failure_i) [*4] |=> error_flag_output_o;
    endproperty
    a_src_window: assert property (p_src_window) else $error("error low after edges");
    property p_drv_off;
        (mode_normal_o && driver_off_i && ec_reg >= 3'h4) [*4] |=> error_flag_output_o;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("error low with driver off");
    property p_lowpwr_pair;
        !split_enable_o |-> error_flag_output_o == rxd_o;
    endproperty
    a_lowpwr_pair: assert property (p_lowpwr_pair) else $error("error and rxd differ");
    property p_hold_time;
        $fell(supply_inhibit_output_o) |-> gs_reg > SLEEP_HOLD_CYC || uv_reg != 16'h0000;
    endproperty
    a_hold_time: assert property (p_hold_time) else $error("inhibit fell early");
    property p_wake_held;
        s_wake_low ##1 !split_enable_o |-> !rxd_o;
    endproperty
    a_wake_held: assert property (p_wake_held) else $error("wake indication lost");
endmodule

bind can_transceiver_mode_control can_transceiver_mode_control_assertions u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .standby_not_input_i(standby_not_input_i),
    .enable_i(enable_i), .txd_i(txd_i), .bus_rx_i(bus_rx_i), .vcc_uv_i(vcc_uv_i),
    .vio_uv_i(vio_uv_i), .vbat_uv_i(vbat_uv_i), .driver_off_i(driver_off_i),
    .bus_failure_i(bus_failure_i), .supply_inhibit_output_o(supply_inhibit_output_o),
    .split_enable_o(split_enable_o), .error_flag_output_o(error_flag_output_o),
    .rxd_o(rxd_o), .mode_normal_o(mode_normal_o), .logic_uv_flag_o(logic_uv_flag_o),
    .vbat_uv_flag_o(vbat_uv_flag_o));

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_i,
    output logic      standby_not_o,
    output logic      enable_o,
    output logic      txd_o
);
    // power up in standby selection, tx recessive
    initial begin
        standby_not_o = 1'h0;
        enable_o = 1'h0;
        txd_o = 1'h1;
    end
    task automatic set_mode(input logic sn, input logic en);
        @(posedge clk_i);
        standby_not_o <= sn;
        enable_o <= en;
    endtask
    // recessive to dominant tx edges
    task automatic tx_edges(input int n);
        repeat (n) begin
            @(posedge clk_i);
            txd_o <= 1'h0;
            repeat (2) @(posedge clk_i);
            txd_o <= 1'h1;
            @(posedge clk_i);
        end
    endtask
endmodule

// ---- tb/can_transceiver_mode_control_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module can_transceiver_mode_control_tb_top;
    logic clk_i = 1'h0, rst_b_i = 1'h0, bus_rx = 1'h1, lwake = 1'h0, bwake = 1'h0;
    logic vcc_uv = 1'h0, vio_uv = 1'h0, vbat_uv = 1'h0, pwrup = 1'h0;
    logic bfail = 1'h0, lfail = 1'h0, doff = 1'h0, sn, en, txd;
    logic supply_inhibit_output, split, err, rxd, mnorm, luv, buv;
    logic [6:0] st;
    int errors = 0, check_count = 0;
    assign st = {mnorm, supply_inhibit_output, split, err, rxd, luv, buv};
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    host_model host (.clk_i(clk_i), .standby_not_o(sn), .enable_o(en), .txd_o(txd));
    can_transceiver_mode_control DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .standby_not_input_i(sn), .enable_i(en), .txd_i(txd), .bus_rx_i(bus_rx),
        .local_wake_input_i(lwake), .bus_wake_i(bwake), .vcc_uv_i(vcc_uv),
        .vio_uv_i(vio_uv), .vbat_uv_i(vbat_uv), .vbat_powerup_i(pwrup),
        .bus_failure_i(bfail), .local_failure_i(lfail), .driver_off_i(doff),
        .supply_inhibit_output_o(supply_inhibit_output), .split_enable_o(split), .error_flag_output_o(err),
        .rxd_o(rxd), .mode_normal_o(mnorm), .logic_uv_flag_o(luv), .vbat_uv_flag_o(buv));
    // wait n rising edges; stimulus then changes by nba on that edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'h1;
        wt(3);
        `CHK(st, 7'h2C)
        host.set_mode(1'h1, 1'h1);
        wt(4);
        `CHK(st, 7'h7C)
        bus_rx <= 1'h0;
        wt(4);
        `CHK(st, 7'h78)
        bus_rx <= 1'h1;
        bfail <= 1'h1;
        wt(4);
        `CHK(st, 7'h7C)
        bfail <= 1'h0;
        host.tx_edges(4);
        doff <= 1'h1;
        wt(6);
        `CHK(st, 7'h7C)
        doff <= 1'h0;
        bfail <= 1'h1;
        wt(4);
        `CHK(st, 7'h74)
        host.set_mode(1'h1, 1'h0);
        bfail <= 1'h0;
        lfail <= 1'h1;
        wt(4);
        `CHK(st, 7'h34)
        lfail <= 1'h0;
        host.set_mode(1'h1, 1'h1);
        wt(4);
        host.set_mode(1'h1, 1'h0);
        wt(4);
        `CHK(st, 7'h3C)
        host.set_mode(1'h0, 1'h0);
        wt(4);
        `CHK(st, 7'h2C)
        lwake <= 1'h1;
        wt(1);
        lwake <= 1'h0;
        wt(10);
        `CHK(st, 7'h20)
        host.set_mode(1'h1, 1'h1);
        wt(4);
        `CHK(st, 7'h74)
        host.tx_edges(4);
        wt(4);
        `CHK(st, 7'h7C)
        host.set_mode(1'h0, 1'h0);
        pwrup <= 1'h1;
        wt(1);
        pwrup <= 1'h0;
        host.set_mode(1'h1, 1'h0);
        wt(4);
        `CHK(st, 7'h34)
        host.set_mode(1'h1, 1'h1);
        wt(4);
        host.set_mode(1'h0, 1'h1);
        wt(1500);
        host.set_mode(1'h0, 1'h0);
        host.set_mode(1'h0, 1'h1);
        wt(1000);
        `CHK(st, 7'h2C)
        wt(1010);
        `CHK(st, 7'h0C)
        host.set_mode(1'h0, 1'h0);
        wt(4);
        `CHK(st, 7'h0C)
        bwake <= 1'h1;
        wt(1);
        bwake <= 1'h0;
        wt(6);
        `CHK(st, 7'h20)
        host.set_mode(1'h1, 1'h1);
        wt(4);
        vcc_uv <= 1'h1;
        wt(300);
        vcc_uv <= 1'h0;
        wt(2);
        vio_uv <= 1'h1;
        wt(300);
        `CHK(st, 7'h7C)
        wt(200);
        `CHK(st, 7'h0E)
        vio_uv <= 1'h0;
        host.set_mode(1'h0, 1'h0);
        wt(6);
        `CHK(st, 7'h0E)
        lwake <= 1'h1;
        wt(1);
        lwake <= 1'h0;
        wt(6);
        `CHK(st, 7'h20)
        host.set_mode(1'h1, 1'h1);
        wt(4);
        vbat_uv <= 1'h1;
        wt(5);
        `CHK(st, 7'h2D)
        vbat_uv <= 1'h0;
        wt(5);
        `CHK(st, 7'h7C)
        final_report();
    end
endmodule
